// File: logic/usa_access_port.sv
// User scan access port: TAP decode, private chain select and TDO retiming.
`timescale 1ns/1ps

module usa_access_port #(
    parameter int CHAIN_NUM    = 1,
    parameter bit DISABLE_PORT = 1'b0,
    parameter bit MASTER_DIE   = 1'b1
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  usa_pkg::usa_addr_t wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  usa_pkg::usa_word_t wb_dat_i,
    output usa_pkg::usa_word_t wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          tck_i,
    input  wire logic          tms_i,
    input  wire logic          tdi_i,
    output logic               tdo_o,
    output logic               tdo_oe_n_o,
    output logic               user_tck_o,
    output logic               user_tms_o,
    output logic               user_tdi_o,
    input  wire logic          user_tdo_i,
    output logic               sel_o,
    output logic               gated_dr_clock_o,
    output logic               tlr_o,
    output logic               update_o,
    output logic               shift_o,
    output logic               capture_o,
    output logic               run_idle_flag_o
);
    import usa_pkg::*;

    // Code this instance answers to; an out-of-range chain number
    // falls back to the first user code rather than to nothing.
    localparam usa_ir_t MY_CODE =
        (CHAIN_NUM == 2) ? `USA_IR_CODE_USER2 :
        (CHAIN_NUM == 3) ? `USA_IR_CODE_USER3 :
        (CHAIN_NUM == 4) ? `USA_IR_CODE_USER4 :
                           `USA_IR_CODE_USER1;
    localparam usa_chain_t CHAIN_ID =
        (CHAIN_NUM == 2) ? 2'h1 :
        (CHAIN_NUM == 3) ? 2'h2 :
        (CHAIN_NUM == 4) ? 2'h3 : 2'h0;
    // A fixed disable in the instance or a placement outside the
    // master die region makes the port inert whatever software asks.
    localparam bit HARD_DISABLE = DISABLE_PORT | ~MASTER_DIE;

    usa_reg_if      regs_bus ();

    usa_tap_state_t state_q;
    usa_tap_state_t state_d;
    usa_ir_t        ir_sh_q;
    usa_ir_t        ir_q;
    logic           sel_q;
    logic           bypass_q;
    logic           tdo_q;
    logic           oe_n_q;
    logic           gated_dr_clock_en_q;
    logic           tck_rst;
    logic           soft_dis_tck;
    logic           disabled_tck;
    logic           hold_tck;
    usa_status_t    status_tck;
    usa_status_t    status_clk;

    // Register slave on the system clock.
    usa_wb_regs u_regs (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .bus      (regs_bus)
    );

    // System reset and the software disable enter the TCK domain.
    usa_sync #(
        .WIDTH (2)
    ) u_to_tck (
        .clk_i (tck_i),
        .d_i   ({rst_i, regs_bus.soft_disable}),
        .q_o   ({tck_rst, soft_dis_tck})
    );

    // TAP status levels return to the system clock domain.
    usa_sync #(
        .WIDTH (`USA_STATUS_W)
    ) u_to_clk (
        .clk_i (clk_i),
        .d_i   (status_tck),
        .q_o   (status_clk)
    );

    // The software bit plays the bitstream option; it can only add
    // a disable, never lift the instance's own one.
    assign disabled_tck = HARD_DISABLE | soft_dis_tck;
    assign hold_tck     = tck_rst | disabled_tck;

    // TAP state machine, advanced by TMS on rising TCK.
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_tlr: begin
                state_d = tms_i ? st_tlr : st_rti;
            end
            st_rti: begin
                state_d = tms_i ? st_sel_dr : st_rti;
            end
            st_sel_dr: begin
                state_d = tms_i ? st_sel_ir : st_cap_dr;
            end
            st_cap_dr: begin
                state_d = tms_i ? st_ex1_dr : st_sh_dr;
            end
            st_sh_dr: begin
                state_d = tms_i ? st_ex1_dr : st_sh_dr;
            end
            st_ex1_dr: begin
                state_d = tms_i ? st_up_dr : st_pa_dr;
            end
            st_pa_dr: begin
                state_d = tms_i ? st_ex2_dr : st_pa_dr;
            end
            st_ex2_dr: begin
                state_d = tms_i ? st_up_dr : st_sh_dr;
            end
            st_up_dr: begin
                state_d = tms_i ? st_sel_dr : st_rti;
            end
            st_sel_ir: begin
                state_d = tms_i ? st_tlr : st_cap_ir;
            end
            st_cap_ir: begin
                state_d = tms_i ? st_ex1_ir : st_sh_ir;
            end
            st_sh_ir: begin
                state_d = tms_i ? st_ex1_ir : st_sh_ir;
            end
            st_ex1_ir: begin
                state_d = tms_i ? st_up_ir : st_pa_ir;
            end
            st_pa_ir: begin
                state_d = tms_i ? st_ex2_ir : st_pa_ir;
            end
            st_ex2_ir: begin
                state_d = tms_i ? st_up_ir : st_sh_ir;
            end
            st_up_ir: begin
                state_d = tms_i ? st_sel_dr : st_rti;
            end
            default: begin
                state_d = st_tlr;
            end
        endcase
    end

    // State register; a disabled port is parked in Test-Logic-Reset,
    // which leaves the chain with no instruction and no TDO.
    always_ff @(posedge tck_i) begin
        if (hold_tck) begin
            state_q <= st_tlr;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction shift register, loaded with the capture pattern and
    // shifted from TDI toward its low end.
    always_ff @(posedge tck_i) begin
        if (hold_tck) begin
            ir_sh_q <= `USA_IR_BYPASS;
        end else if (state_q[`USA_BIT_CAP_IR]) begin
            ir_sh_q <= `USA_IR_CAPTURE;
        end else if (state_q[`USA_BIT_SH_IR]) begin
            ir_sh_q <= {tdi_i, ir_sh_q[`USA_IR_W-1:1]};
        end
    end

    // Active instruction and chain select change only in Update-IR, in Test-Logic-Reset and while the port is held,
    // so select is steady across a whole data-register scan.
    always_ff @(posedge tck_i) begin
        if (hold_tck | state_q[`USA_BIT_TLR]) begin
            ir_q  <= `USA_IR_BYPASS;
            sel_q <= 1'b0;
        end else if (state_q[`USA_BIT_UP_IR]) begin
            ir_q  <= ir_sh_q;
            sel_q <= (ir_sh_q == MY_CODE);
        end
    end

    // One-bit bypass path for every code this instance does not own.
    always_ff @(posedge tck_i) begin
        if (hold_tck) begin
            bypass_q <= 1'b0;
        end else if (state_q[`USA_BIT_CAP_DR]) begin
            bypass_q <= 1'b0;
        end else if (state_q[`USA_BIT_SH_DR]) begin
            bypass_q <= tdi_i;
        end
    end

    // Falling-edge output stage. The user's TDO is retimed here so
    // that the far end samples a half period of settled data; it
    // comes from fabric scan cells, not from boundary cells.
    always_ff @(negedge tck_i) begin
        if (hold_tck) begin
            tdo_q <= 1'b0;
        end else if (state_q[`USA_BIT_SH_IR]) begin
            tdo_q <= ir_sh_q[0];
        end else if (sel_q) begin
            tdo_q <= user_tdo_i;
        end else begin
            tdo_q <= bypass_q;
        end
    end

    // The pin is driven only while shifting; a disabled port never
    // drives it, which breaks the chain at this device.
    always_ff @(negedge tck_i) begin
        if (hold_tck) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~(state_q[`USA_BIT_SH_DR] | state_q[`USA_BIT_SH_IR]);
        end
    end

    // Gate enable changes while TCK is low, so the gated clock has
    // no runt pulses. The rising edge that leaves Capture-DR is the
    // capture edge for the user's cells.
    always_ff @(negedge tck_i) begin
        if (hold_tck) begin
            gated_dr_clock_en_q <= 1'b0;
        end else begin
            gated_dr_clock_en_q <= sel_q & (state_q[`USA_BIT_CAP_DR] |
                                  state_q[`USA_BIT_SH_DR]);
        end
    end

    // Pin levels pass inward unchanged; a register here would skew
    // them against the TAP by a cycle.
    assign user_tck_o = tck_i;
    assign user_tms_o = tms_i;
    assign user_tdi_o = tdi_i;

    // Data-register clock for the user's chain; the user captures
    // and shifts on it while select is high.
    assign gated_dr_clock_o = tck_i & gated_dr_clock_en_q;

    // Strobes are bits of the one-hot state register. The user's
    // holding register loads on the rise of update.
    assign tlr_o           = state_q[`USA_BIT_TLR];
    assign capture_o       = state_q[`USA_BIT_CAP_DR];
    assign shift_o         = state_q[`USA_BIT_SH_DR];
    assign update_o        = state_q[`USA_BIT_UP_DR];
    assign run_idle_flag_o = state_q[`USA_BIT_RTI];
    assign sel_o           = sel_q;
    assign tdo_o           = tdo_q;
    assign tdo_oe_n_o      = oe_n_q;

    // Status levels gathered for the crossing back to the bus clock.
    always_comb begin
        status_tck = '0;
        status_tck[`USA_STS_RUN_IDLE] = state_q[`USA_BIT_RTI];
        status_tck[`USA_STS_SEL]      = sel_q;
        status_tck[`USA_STS_TLR]      = state_q[`USA_BIT_TLR];
        status_tck[`USA_STS_CAPTURE]  = state_q[`USA_BIT_CAP_DR];
        status_tck[`USA_STS_SHIFT]    = state_q[`USA_BIT_SH_DR];
        status_tck[`USA_STS_UPDATE]   = state_q[`USA_BIT_UP_DR];
        status_tck[`USA_STS_DISABLED] = disabled_tck;
    end

    // Status seen by software lags the TAP by the crossing depth and
    // misses strobes shorter than that; it is a monitor only.
    assign regs_bus.status   = status_clk;
    assign regs_bus.chain_id = CHAIN_ID;
endmodule : usa_access_port

// File: logic/usa_cfg.svh
// Constants for the user scan access port: codes, offsets and bit positions.
`ifndef USA_CFG_SVH
`define USA_CFG_SVH

// Instruction register width and instruction codes.
`define USA_IR_W          6
`define USA_IR_CODE_USER1 6'h20
`define USA_IR_CODE_USER2 6'h21
`define USA_IR_CODE_USER3 6'h22
`define USA_IR_CODE_USER4 6'h23
`define USA_IR_CAPTURE    6'h01
`define USA_IR_BYPASS     6'h3F

// Register bus geometry and byte offsets.
`define USA_BUS_AW        4
`define USA_BUS_DW        32
`define USA_ADR_CTRL      4'h0
`define USA_ADR_STATUS    4'h4

// Control register fields and reset values.
`define USA_CTRL_DIS_BIT  0
`define USA_CTRL_DIS_RST  1'b0

// Status vector bit positions.
`define USA_STATUS_W      7
`define USA_STS_RUN_IDLE  0
`define USA_STS_SEL       1
`define USA_STS_TLR       2
`define USA_STS_CAPTURE   3
`define USA_STS_SHIFT     4
`define USA_STS_UPDATE    5
`define USA_STS_DISABLED  6
`define USA_CHAIN_LSB     8
`define USA_CHAIN_W       2

// One-hot TAP state bit positions.
`define USA_ST_W          16
`define USA_BIT_TLR       0
`define USA_BIT_RTI       1
`define USA_BIT_CAP_DR    3
`define USA_BIT_SH_DR     4
`define USA_BIT_UP_DR     8
`define USA_BIT_CAP_IR    10
`define USA_BIT_SH_IR     11
`define USA_BIT_UP_IR     15

`endif

// File: logic/usa_pkg.sv
// Types shared by the user scan access port modules.
package usa_pkg;
    `include "usa_cfg.svh"

    typedef enum logic [`USA_ST_W-1:0] {
        st_tlr     = 16'h0001,
        st_rti     = 16'h0002,
        st_sel_dr  = 16'h0004,
        st_cap_dr  = 16'h0008,
        st_sh_dr   = 16'h0010,
        st_ex1_dr  = 16'h0020,
        st_pa_dr   = 16'h0040,
        st_ex2_dr  = 16'h0080,
        st_up_dr   = 16'h0100,
        st_sel_ir  = 16'h0200,
        st_cap_ir  = 16'h0400,
        st_sh_ir   = 16'h0800,
        st_ex1_ir  = 16'h1000,
        st_pa_ir   = 16'h2000,
        st_ex2_ir  = 16'h4000,
        st_up_ir   = 16'h8000
    } usa_tap_state_t;

    typedef logic [`USA_IR_W-1:0]      usa_ir_t;
    typedef logic [`USA_STATUS_W-1:0]  usa_status_t;
    typedef logic [`USA_CHAIN_W-1:0]   usa_chain_t;
    typedef logic [`USA_BUS_DW-1:0]    usa_word_t;
    typedef logic [`USA_BUS_AW-1:0]    usa_addr_t;
endpackage : usa_pkg

// File: logic/usa_reg_if.sv
// Bundle between the register slave and the scan port core.
`timescale 1ns/1ps
interface usa_reg_if;
    import usa_pkg::*;
    logic        soft_disable;
    usa_status_t status;
    usa_chain_t  chain_id;

    modport regs (output soft_disable, input status, input chain_id);
    modport core (input soft_disable, output status, output chain_id);
endinterface : usa_reg_if

// File: logic/usa_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module usa_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    import usa_pkg::*;

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // Each bit crosses alone; the stages carry no reset so that the
    // crossing of the reset itself has no circular dependency.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            s1_q[i] <= d_i[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
                q_o[i] <= s3_q[i];
            end
        end
    end
endmodule : usa_sync

// File: logic/usa_wb_regs.sv
// Classic Wishbone slave holding the control and status registers.
`timescale 1ns/1ps
module usa_wb_regs (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  usa_pkg::usa_addr_t wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  usa_pkg::usa_word_t wb_dat_i,
    output usa_pkg::usa_word_t wb_dat_o,
    output logic              wb_ack_o,
    usa_reg_if.regs           bus
);
    import usa_pkg::*;

    logic      ack_q;
    logic      dis_q;
    usa_word_t rdata_q;
    usa_word_t rdata_d;
    logic      req;

    assign req          = wb_cyc_i & wb_stb_i;
    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdata_q;
    assign bus.soft_disable = dis_q;

    // Answer one cycle after the request and drop ack the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Unmapped or unaligned addresses read as zero.
    always_comb begin
        rdata_d = '0;
        case (wb_adr_i)
            `USA_ADR_CTRL: begin
                rdata_d[`USA_CTRL_DIS_BIT] = dis_q;
            end
            `USA_ADR_STATUS: begin
                rdata_d[`USA_STATUS_W-1:0] = bus.status;
                rdata_d[`USA_CHAIN_LSB +: `USA_CHAIN_W] = bus.chain_id;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // Read data is captured together with the ack it travels with.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (req & ~ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    // Writes land on the edge where the master sees ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dis_q <= `USA_CTRL_DIS_RST;
        end else if (req & wb_we_i & ack_q & wb_sel_i[0] &
                     (wb_adr_i == `USA_ADR_CTRL)) begin
            dis_q <= wb_dat_i[`USA_CTRL_DIS_BIT];
        end
    end
endmodule : usa_wb_regs

// File: test/tb_top.sv
// Self-checking bench for the user scan access port.
`timescale 1ns/1ps
`include "usa_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; \
    if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import usa_pkg::*;
    int         errors = 0;
    int         num_checks = 0;
    int         n_gate = 0;
    logic       clk_i = 1'b0, rst_i = 1'b1, tck_i = 1'b0;
    logic       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic       tms_i = 1'b1, tdi_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    usa_addr_t  wb_adr_i = '0;
    usa_word_t  wb_dat_i = '0, wb_dat_o;
    logic       wb_ack_o, tdo_o, tdo_oe_n_o, user_tck_o, user_tms_o;
    logic       user_tdi_o, user_tdo_i, sel_o, gated_dr_clock_o, tlr_o;
    logic       update_o, shift_o, capture_o, run_idle_flag_o;
    logic       dis_tlr, dis_sel;
    logic [7:0] hold_w;

    usa_access_port uut (.*);
    // A copy built disabled shares every input with the first.
    usa_access_port #(.DISABLE_PORT(1'b1)) uut_dis (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o(), .wb_ack_o(), .tck_i, .tms_i, .tdi_i,
        .tdo_o(), .tdo_oe_n_o(), .user_tck_o(), .user_tms_o(), .user_tdi_o(),
        .user_tdo_i, .sel_o(dis_sel), .gated_dr_clock_o(), .tlr_o(dis_tlr),
        .update_o(), .shift_o(), .capture_o(), .run_idle_flag_o()
    );
    usa_user_chain #(.W(8)) u_chain (
        .dr_clk_i(gated_dr_clock_o), .sel_i(sel_o), .capture_i(capture_o),
        .shift_i(shift_o), .update_i(update_o), .tdi_i(user_tdi_o),
        .tdo_o(user_tdo_i), .hold_o(hold_w)
    );

    // Bus clock at 5 ns; link clock at 12 ns with an unrelated phase.
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #1.3;
        forever #6 tck_i = ~tck_i;
    end
    always @(posedge gated_dr_clock_o) n_gate++;

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb_io(input logic we, input usa_addr_t adr,
                         input logic [3:0] sel, input usa_word_t dat,
                         output usa_word_t rd);
        int t;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        for (t = 0; t < 50; t++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (t == 50) begin
            errors++;
            test_done();
        end
    endtask : wb_io

    // Master pins move after a falling edge; TDO is read at the rise.
    task automatic step(input logic ms, input logic di, output logic dout);
        @(negedge tck_i);
        tms_i <= ms;
        tdi_i <= di;
        @(posedge tck_i);
        dout = tdo_o;
    endtask : step

    // Scan n bits LSB first through IR or DR, from idle back to idle.
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        #1;
        if (!ir) `CHK("capture", 1'b1, capture_o)
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        #1;
        if (!ir) `CHK("update", 1'b1, update_o)
        step(1'b0, 1'b0, b);
        #1;
        `CHK("idle", 1'b1, run_idle_flag_o)
    endtask : scan

    initial begin
        logic [31:0] r, d, ev;
        logic [7:0]  hold_m;
        logic        b;
        int          w;
        hold_m = '0;
        void'($urandom(32'h5ae1c0d8));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        // The state flop moves at the edge that step returns on; settle first.
        #1;
        `CHK("tlr", 1'b0, tlr_o)
        `CHK("tck fwd", tck_i, user_tck_o)
        repeat (30) @(posedge clk_i);
        wb_io(1'b0, `USA_ADR_STATUS, 4'hF, '0, r);
        `CHK("status", 32'h1 << `USA_STS_RUN_IDLE, r)
        // Unmapped and byte-masked writes must leave nothing behind.
        wb_io(1'b1, 4'h8, 4'hF, $urandom, r);
        wb_io(1'b0, 4'h8, 4'hF, '0, r);
        `CHK("unmapped", 32'h0, r)
        wb_io(1'b1, `USA_ADR_CTRL, 4'hE, 32'h1, r);
        wb_io(1'b0, `USA_ADR_CTRL, 4'hF, '0, r);
        `CHK("ctrl", 32'h0, r)
        // Every user code twice; only the first chain owns its scans.
        for (int k = 0; k < 8; k++) begin
            scan(1'b1, `USA_IR_CODE_USER1 + k % 4, 6, r);
            `CHK("ir cap", `USA_IR_CAPTURE, r[5:0])
            `CHK("sel", k % 4 == 0, sel_o)
            d = $urandom;
            n_gate = 0;
            scan(1'b0, d, 8, r);
            ev = (k % 4 == 0) ? {24'h0, hold_m} : {d[6:0], 1'b0};
            `CHK("dr out", ev[7:0], r[7:0])
            `CHK("gate", (k % 4 == 0) ? 9 : 0, n_gate)
            `CHK("dis tlr", 1'b1, dis_tlr)
            `CHK("dis sel", 1'b0, dis_sel)
            if (k % 4 == 0) hold_m = d[7:0];
        end
        // Soft disable from the bus while a user chain is selected.
        scan(1'b1, `USA_IR_CODE_USER1, 6, r);
        wb_io(1'b1, `USA_ADR_CTRL, 4'hF, 32'h1, r);
        for (w = 0; w < 200 && tlr_o !== 1'b1; w++) @(posedge clk_i);
        if (w == 200) begin
            errors++;
            test_done();
        end
        repeat (30) @(posedge clk_i);
        `CHK("soft sel", 1'b0, sel_o)
        `CHK("soft oe", 1'b1, tdo_oe_n_o)
        wb_io(1'b0, `USA_ADR_STATUS, 4'hF, '0, r);
        ev = (32'h1 << `USA_STS_TLR) | (32'h1 << `USA_STS_DISABLED);
        `CHK("status dis", ev, r)
        wb_io(1'b1, `USA_ADR_CTRL, 4'hF, 32'h0, r);
        repeat (30) @(posedge clk_i);
        step(1'b0, 1'b0, b);
        scan(1'b1, `USA_IR_CODE_USER1, 6, r);
        `CHK("sel back", 1'b1, sel_o)
        test_done();
    end
endmodule : tb_top

// File: test/usa_access_port_chk.sv
// Concurrent checks on the pins of the user scan access port.
`timescale 1ns/1ps
module usa_access_port_chk #(
    parameter int CHAIN_NUM    = 1,
    parameter bit DISABLE_PORT = 1'b0,
    parameter bit MASTER_DIE   = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_n_o,
    input wire logic user_tms_o,
    input wire logic user_tdi_o,
    input wire logic user_tdo_i,
    input wire logic sel_o,
    input wire logic gated_dr_clock_o,
    input wire logic tlr_o,
    input wire logic update_o,
    input wire logic shift_o,
    input wire logic capture_o,
    input wire logic run_idle_flag_o
);
    // Leaving Capture-DR with TMS low must land in Shift-DR.
    sequence s_cap_go;
        capture_o && !tms_i;
    endsequence
    property p_cap_shift;
        @(posedge tck_i) disable iff (rst_i) s_cap_go |=> shift_o;
    endproperty
    a_cap_shift: assert property (p_cap_shift)
        else $error("Capture-DR did not step to Shift-DR.");
    property p_upd_idle;
        @(posedge tck_i) disable iff (rst_i)
            update_o && !tms_i |=> run_idle_flag_o;
    endproperty
    a_upd_idle: assert property (p_upd_idle)
        else $error("Update-DR did not step to idle.");
    // The decoded states exclude one another.
    property p_onehot;
        @(posedge tck_i) disable iff (rst_i)
            $onehot0({tlr_o, capture_o, shift_o, update_o, run_idle_flag_o});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("Two state strobes high together.");
    // TDO is the user bit taken at the previous falling edge.
    property p_tdo;
        @(negedge tck_i) disable iff (rst_i)
            sel_o && shift_o |=> !tdo_oe_n_o && tdo_o == $past(user_tdo_i);
    endproperty
    a_tdo: assert property (p_tdo)
        else $error("TDO pin not retimed from user data.");
    // The gate enable is latched on a falling edge, so compare one back.
    property p_gate;
        @(negedge tck_i) disable iff (rst_i)
            gated_dr_clock_o == $past(sel_o && (capture_o || shift_o));
    endproperty
    a_gate: assert property (p_gate)
        else $error("Gated clock pulse without select and scan.");
    property p_dis;
        @(posedge tck_i) disable iff (rst_i)
            (DISABLE_PORT || !MASTER_DIE) |-> tlr_o && !sel_o && tdo_oe_n_o;
    endproperty
    a_dis: assert property (p_dis)
        else $error("Disabled port left the chain usable.");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
            wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("Bus acknowledge late or too long.");
    property p_fwd;
        @(posedge clk_i) disable iff (rst_i)
            user_tdi_o == tdi_i && user_tms_o == tms_i;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("Pin copy differs from the pin.");
endmodule : usa_access_port_chk

bind usa_access_port usa_access_port_chk #(
    .CHAIN_NUM(CHAIN_NUM), .DISABLE_PORT(DISABLE_PORT),
    .MASTER_DIE(MASTER_DIE)
) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .user_tms_o(user_tms_o),
    .user_tdi_o(user_tdi_o), .user_tdo_i(user_tdo_i), .sel_o(sel_o),
    .gated_dr_clock_o(gated_dr_clock_o), .tlr_o(tlr_o),
    .update_o(update_o), .shift_o(shift_o), .capture_o(capture_o),
    .run_idle_flag_o(run_idle_flag_o)
);

// File: test/usa_user_chain.sv
// Behavioural user scan register standing behind the access port.
`timescale 1ns/1ps
module usa_user_chain #(
    parameter int W = 8
) (
    input  wire logic    dr_clk_i,
    input  wire logic    sel_i,
    input  wire logic    capture_i,
    input  wire logic    shift_i,
    input  wire logic    update_i,
    input  wire logic    tdi_i,
    output logic         tdo_o,
    output logic [W-1:0] hold_o
);
    logic [W-1:0] sr_q = '0;
    initial hold_o = '0;
    // Capture the held word, else shift one bit toward the TDO end.
    always @(posedge dr_clk_i) begin
        if (sel_i && capture_i) sr_q <= hold_o;
        else if (sel_i && shift_i) sr_q <= {tdi_i, sr_q[W-1:1]};
    end
    // Parallel transfer on the rising update strobe.
    always @(posedge update_i) begin
        if (sel_i) hold_o <= sr_q;
    end
    // Unaddressed, the line carries the inverse so a stale bit cannot match.
    assign tdo_o = sel_i ? sr_q[0] : ~sr_q[0];
endmodule : usa_user_chain
